// ==== src/pbm_basic_mode_control.sv ====
// Purpose: Basic mode control word of a 10/100 PHY with an AXI4-Lite slave
// Assumes: Single 50 MHz clock; MII and negotiation engine share it
// Notes:   Hardware reset runs the same sequence as a software reset
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
// Contract
// - Writing one to bit 15 starts a full reset of the transceiver logic.
// - When that reset ends, bit 15 clears itself and the strap is captured again.
// - Bit 15 reads one while the reset runs and zero in normal operation.
// - Bit 14 loops MII transmit data back to MII receive and resets to zero.
// - With negotiation off, bit 13 picks 100 Mb/s at one and 10 Mb/s at zero, reset one.
// - With bit 12 at one, its reset value, bits 13 and 8 are ignored.
// - With bit 12 at zero, speed and duplex come straight from bits 13 and 8.
// - Bit 11 powers the transceiver down leaving only register access, reset zero.
// - Power down in effect is bit 11 ORed with the pin request.
// - A low level on the interrupt or power-down pin sets bit 11.
// - Bit 10 cuts the port off the MII but keeps management working, reset zero.
// - With negotiation off, bit 8 picks full duplex at one and half at zero.
// - Writing one to bit 9 restarts negotiation, reads one until it starts, else ignored.
module pbm_basic_mode_control
	import pbm_pkg::*;
#(
	parameter int SW_RESET_CYCLES = SWRST_CYCLES
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [AXI_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  irqOrPowerdownPin_b,
	input  wire logic                  strapDuplexPin,
	input  wire logic                  anSpeed100,
	input  wire logic                  anFullDuplex,
	input  wire logic                  anStarted,
	input  wire pbm_mii_tx_s           miiTxIn,
	input  wire pbm_mii_rx_s           coreRxIn,
	output pbm_mii_rx_s                miiRxOut,
	output logic                       miiRxOe,
	output pbm_mii_tx_s                coreTxOut,
	output logic                       phyCoreReset,
	output logic                       pwrDown,
	output logic                       linkSpeed100,
	output logic                       linkFullDuplex,
	output logic                       anEnable,
	output logic                       anRestart
);
	// ==========================================================
	// Local widths
	localparam int CW = $clog2(SW_RESET_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(SW_RESET_CYCLES);
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);

	// Word-aligned address match, shared by both decoders
	function automatic logic regHit(
		input logic [AXI_ADDR_W-1:0] addr,
		input logic [AXI_ADDR_W-1:0] ofs
	);
		regHit = (addr[AXI_ADDR_W-1:2] == ofs[AXI_ADDR_W-1:2]);
	endfunction : regHit

	// ==========================================================
	// Pin synchronisation
	logic [SYNC_W-1:0] pinSync;
	wire               pinPwrDnReq = ~pinSync[1];
	wire               strapDuplex = pinSync[0];

	pbm_pin_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST)
	) uPinSync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pinIn    ({irqOrPowerdownPin_b, strapDuplexPin}),
		.pinOut   (pinSync)
	);

	// ==========================================================
	// Control state
	logic [CW-1:0] rstCnt_r;
	logic [CW-1:0] rstCnt_nxt;
	logic          loop_r;
	logic          speed_r;
	logic          anEn_r;
	logic          pd_r;
	logic          iso_r;
	logic          restart_r;
	logic          duplex_r;

	// ==========================================================
	// AXI4-Lite write channel state
	logic                  awTaken_r;
	logic                  wTaken_r;
	logic [AXI_ADDR_W-1:0] awAddr_r;
	logic [AXI_DATA_W-1:0] wData_r;
	logic [AXI_STRB_W-1:0] wStrb_r;

	// Write commits once both halves are held and no response is pending
	wire doWrite  = awTaken_r & wTaken_r & ~s_axi_bvalid;
	wire wrCtrl   = doWrite & regHit(awAddr_r, OFS_BASIC_CTRL);
	wire wrStatus = doWrite & regHit(awAddr_r, OFS_STATUS);
	wire wrMapped = wrCtrl | wrStatus;
	wire laneHit  = wStrb_r[CTRL_LANE];
	wire busy     = (rstCnt_r != '0);

	// Control writes only count with lane 1 enabled and no reset running
	wire ctrlWe    = wrCtrl & laneHit & ~busy;
	wire wrReset   = ctrlWe & wData_r[BIT_SWRESET];
	wire wrFields  = ctrlWe & ~wData_r[BIT_SWRESET];
	wire rstDone   = (rstCnt_r == CNT_ONE);
	wire newAnEn   = wData_r[BIT_ANEN];
	wire restartWr = wrFields & newAnEn & wData_r[BIT_ANRESTART];

	// Reset counter loads on a reset write and runs down to idle
	always_comb begin
		rstCnt_nxt = rstCnt_r;
		if (wrReset) begin
			rstCnt_nxt = CNT_LOAD;
		end else if (busy) begin
			rstCnt_nxt = rstCnt_r - CNT_ONE;
		end
	end

	// Hardware reset loads the counter so straps settle before capture
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rstCnt_r <= CNT_LOAD;
		end else begin
			rstCnt_r <= rstCnt_nxt;
		end
	end

	// ==========================================================
	// Control fields
	// During the reset sequence every field but duplex is held at its default
	always_ff @(posedge core_clk) begin
		if (!rst_b || busy || wrReset) begin
			loop_r  <= RST_LOOPBACK;
			speed_r <= RST_SPEED;
			anEn_r  <= RST_ANEN;
			iso_r   <= RST_ISOLATE;
		end else if (wrFields) begin
			loop_r  <= wData_r[BIT_LOOPBACK];
			speed_r <= wData_r[BIT_SPEED];
			anEn_r  <= newAnEn;
			iso_r   <= wData_r[BIT_ISOLATE];
		end
	end

	// Pin request wins over a software clear of the power-down bit
	always_ff @(posedge core_clk) begin
		if (!rst_b || busy || wrReset) begin
			pd_r <= RST_PWRDN;
		end else if (pinPwrDnReq) begin
			pd_r <= 1'b1;
		end else if (wrFields) begin
			pd_r <= wData_r[BIT_PWRDN];
		end
	end

	// Duplex takes the strap at the end of each reset sequence
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			duplex_r <= RST_DUPLEX;
		end else if (rstDone) begin
			duplex_r <= strapDuplex;
		end else if (wrFields) begin
			duplex_r <= wData_r[BIT_DUPLEX];
		end
	end

	// A fresh restart write beats the engine's start pulse in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_b || busy || wrReset) begin
			restart_r <= RST_ANRESTART;
		end else if (restartWr) begin
			restart_r <= 1'b1;
		end else if (anStarted || !anEn_r) begin
			restart_r <= 1'b0;
		end
	end

	// ==========================================================
	// Effective operating mode
	wire effPwrDn  = pd_r | pinPwrDnReq;
	wire effSpeed  = anEn_r ? anSpeed100 : speed_r;
	wire effDuplex = anEn_r ? anFullDuplex : duplex_r;
	wire quiet     = effPwrDn | busy | wrReset;

	// Mode outputs are registered so every output leaves a flip-flop
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			phyCoreReset   <= 1'b1;
			pwrDown        <= 1'b0;
			linkSpeed100   <= RST_SPEED;
			linkFullDuplex <= RST_DUPLEX;
			anEnable       <= RST_ANEN;
			anRestart      <= RST_ANRESTART;
		end else begin
			phyCoreReset   <= busy | wrReset;
			pwrDown        <= effPwrDn;
			linkSpeed100   <= effSpeed;
			linkFullDuplex <= effDuplex;
			anEnable       <= anEn_r;
			anRestart      <= restart_r & anEn_r;
		end
	end

	// ==========================================================
	// MII steering
	// Isolation releases the receive drivers so other PHYs may share the MAC
	pbm_mii_path uMiiPath (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.loopback (loop_r),
		.isolate  (iso_r),
		.quiet    (quiet),
		.macTx    (miiTxIn),
		.coreRx   (coreRxIn),
		.macRx    (miiRxOut),
		.macRxOe  (miiRxOe),
		.coreTx   (coreTxOut)
	);

	// ==========================================================
	// Read data assembly
	logic [AXI_DATA_W-1:0] ctrlWord;
	logic [AXI_DATA_W-1:0] statusWord;

	// Unused bits read as zero; bit 15 mirrors the running reset
	always_comb begin
		ctrlWord                = '0;
		ctrlWord[BIT_SWRESET]   = busy;
		ctrlWord[BIT_LOOPBACK]  = loop_r;
		ctrlWord[BIT_SPEED]     = speed_r;
		ctrlWord[BIT_ANEN]      = anEn_r;
		ctrlWord[BIT_PWRDN]     = pd_r;
		ctrlWord[BIT_ISOLATE]   = iso_r;
		ctrlWord[BIT_ANRESTART] = restart_r;
		ctrlWord[BIT_DUPLEX]    = duplex_r;
	end

	// Status shows what the port really runs with
	always_comb begin
		statusWord              = '0;
		statusWord[STS_BUSY]    = busy;
		statusWord[STS_SPEED]   = effSpeed;
		statusWord[STS_DUPLEX]  = effDuplex;
		statusWord[STS_PWRDN]   = effPwrDn;
		statusWord[STS_PINPD]   = pinPwrDnReq;
		statusWord[STS_ISOLATE] = iso_r;
		statusWord[STS_RESTART] = restart_r;
	end

	wire rdCtrl   = regHit(s_axi_araddr, OFS_BASIC_CTRL);
	wire rdStatus = regHit(s_axi_araddr, OFS_STATUS);
	wire arFire   = s_axi_arvalid & s_axi_arready;
	wire [AXI_DATA_W-1:0] rdMux = rdCtrl ? ctrlWord : (rdStatus ? statusWord : '0);
	wire [1:0]            rdResp = (rdCtrl | rdStatus) ? RESP_OKAY : RESP_SLVERR;

	// ==========================================================
	// AXI4-Lite write address and data capture
	// Address and data are accepted independently, in either order
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			awTaken_r <= 1'b0;
			awAddr_r  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awTaken_r <= 1'b1;
			awAddr_r  <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			awTaken_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wTaken_r <= 1'b0;
			wData_r  <= '0;
			wStrb_r  <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wTaken_r <= 1'b1;
			wData_r  <= s_axi_wdata;
			wStrb_r  <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			wTaken_r <= 1'b0;
		end
	end

	// Ready drops on acceptance and returns once the response is taken
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write response
	// A write during the reset sequence is acknowledged but has no effect
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	// Reads stay live in power down so software can wake the port
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (arFire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdMux;
			s_axi_rresp   <= rdResp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end
endmodule : pbm_basic_mode_control

// ==== src/pbm_pkg.sv ====
// Purpose: Shared constants and carriers for the PHY basic mode control block
// Assumes: One 50 MHz management clock; AXI4-Lite register access with 32-bit data
// Notes:   Control bits 15:8 sit in byte lane 1; bits 7:0 read as zero
package pbm_pkg;
	// ==========================================================
	// Bus geometry and register map
	localparam int                    AXI_ADDR_W     = 8;
	localparam int                    AXI_DATA_W     = 32;
	localparam int                    AXI_STRB_W     = 4;
	localparam logic [AXI_ADDR_W-1:0] OFS_BASIC_CTRL = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_STATUS     = 8'h04;
	localparam logic [1:0]            RESP_OKAY      = 2'h0;
	localparam logic [1:0]            RESP_SLVERR    = 2'h2;
	localparam int                    CTRL_LANE      = 1;

	// ==========================================================
	// Control word field positions
	localparam int BIT_SWRESET   = 15;
	localparam int BIT_LOOPBACK  = 14;
	localparam int BIT_SPEED     = 13;
	localparam int BIT_ANEN      = 12;
	localparam int BIT_PWRDN     = 11;
	localparam int BIT_ISOLATE   = 10;
	localparam int BIT_ANRESTART = 9;
	localparam int BIT_DUPLEX    = 8;

	// ==========================================================
	// Control word reset values
	localparam logic RST_LOOPBACK  = 1'b0;
	localparam logic RST_SPEED     = 1'b1;
	localparam logic RST_ANEN      = 1'b1;
	localparam logic RST_PWRDN     = 1'b0;
	localparam logic RST_ISOLATE   = 1'b0;
	localparam logic RST_ANRESTART = 1'b0;
	localparam logic RST_DUPLEX    = 1'b1;

	// ==========================================================
	// Status word field positions
	localparam int STS_BUSY    = 0;
	localparam int STS_SPEED   = 1;
	localparam int STS_DUPLEX  = 2;
	localparam int STS_PWRDN   = 3;
	localparam int STS_PINPD   = 4;
	localparam int STS_ISOLATE = 5;
	localparam int STS_RESTART = 6;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SWRST_TIME_NS = 1000;
	localparam int SWRST_CYCLES  = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_W        = 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = 2'h3;

	// ==========================================================
	// MII carriers
	typedef struct packed {
		logic       en;
		logic [3:0] d;
		logic       er;
	} pbm_mii_tx_s;

	typedef struct packed {
		logic       dv;
		logic [3:0] d;
		logic       er;
	} pbm_mii_rx_s;
endpackage : pbm_pkg

// ==== src/pbm_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module pbm_pin_sync #(
	parameter int             W       = 2,
	parameter logic [W-1:0]   RST_VAL = '1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	// ==========================================================
	// Stages
	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;
	logic [W-1:0] stage3_r;
	wire  [W-1:0] agree = ~(stage2_r ^ stage3_r);

	// Stage one feeds stage two only, so no logic sees a metastable value
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stage1_r <= RST_VAL;
			stage2_r <= RST_VAL;
			stage3_r <= RST_VAL;
			pinOut   <= RST_VAL;
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			pinOut   <= (agree & stage3_r) | (~agree & pinOut);
		end
	end
endmodule : pbm_pin_sync

// ==== src/pbm_mii_path.sv ====
// Purpose: MII data steering for loopback, isolation and quiet states
// Assumes: MII signals are on core_clk
// Notes:   One register stage on every path
`timescale 1ns/1ps
module pbm_mii_path
	import pbm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        loopback,
	input  wire logic        isolate,
	input  wire logic        quiet,
	input  wire pbm_mii_tx_s macTx,
	input  wire pbm_mii_rx_s coreRx,
	output pbm_mii_rx_s      macRx,
	output logic             macRxOe,
	output pbm_mii_tx_s      coreTx
);
	// ==========================================================
	// Steering
	wire         txBlocked = loopback | isolate | quiet;
	wire         rxMuted   = isolate | quiet;
	pbm_mii_rx_s loopRx;
	pbm_mii_rx_s rxSrc;
	assign loopRx = '{dv: macTx.en, d: macTx.d, er: macTx.er};
	assign rxSrc  = loopback ? loopRx : coreRx;

	// Loopback keeps looped frames off the line side
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			macRx   <= '0;
			macRxOe <= 1'b0;
			coreTx  <= '0;
		end else begin
			macRx   <= rxMuted ? '0 : rxSrc;
			macRxOe <= ~isolate;
			coreTx  <= txBlocked ? '0 : macTx;
		end
	end
endmodule : pbm_mii_path

// ==== tb/pbm_bmc_assertions.sv ====
// Purpose: Port level checks for the basic mode control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the design from the testbench top file
`timescale 1ns/1ps
module pbm_bmc_assertions
	import pbm_pkg::*;
#(
	parameter int SW_RESET_CYCLES = SWRST_CYCLES
) (
	input wire logic                  core_clk,
	input wire logic                  rst_b,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic                  irqOrPowerdownPin_b,
	input wire logic                  anSpeed100,
	input wire logic                  anFullDuplex,
	input wire pbm_mii_rx_s           miiRxOut,
	input wire logic                  miiRxOe,
	input wire pbm_mii_tx_s           coreTxOut,
	input wire logic                  phyCoreReset,
	input wire logic                  pwrDown,
	input wire logic                  linkSpeed100,
	input wire logic                  linkFullDuplex,
	input wire logic                  anEnable,
	input wire logic                  anRestart
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Helper: length of the current reset sequence in cycles
	logic [7:0] busyCnt_r;
	always_ff @(posedge core_clk) begin
		if (!rst_b) busyCnt_r <= 8'h00;
		else if (phyCoreReset) busyCnt_r <= busyCnt_r + 8'h01;
		else busyCnt_r <= 8'h00;
	end
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence anSteady;
		anEnable && !phyCoreReset && $stable(anSpeed100) && $stable(anFullDuplex);
	endsequence
	// ==========================================================
	// Bus answers and holding
	chk_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// ==========================================================
	// Control effects
	chk_reset_length: assert property ($fell(phyCoreReset) |-> busyCnt_r >= SW_RESET_CYCLES - 1 && busyCnt_r <= SW_RESET_CYCLES + 1)
		else $error("reset sequence length wrong");
	chk_busy_quiet: assert property (phyCoreReset [*2] |-> miiRxOut == '0 && coreTxOut == '0)
		else $error("MII active during reset");
	chk_pin_powerdown: assert property (!irqOrPowerdownPin_b [*8] |-> pwrDown)
		else $error("pin power down not applied");
	chk_an_follows: assert property (anSteady [*3] |-> linkSpeed100 == anSpeed100 && linkFullDuplex == anFullDuplex)
		else $error("negotiated mode not used");
	chk_restart_needs_an: assert property (!anEnable |-> !anRestart)
		else $error("restart while negotiation off");
	chk_isolate_release: assert property (!miiRxOe |-> miiRxOut == '0)
		else $error("receive data while released");
endmodule : pbm_bmc_assertions

// ==== tb/pbm_mac_model.sv ====
// Purpose: MAC transmit side facing the block
// Assumes: Transmit runs on core_clk
// Notes:   Eight-beat frames; idle data toggles so stale values never look valid
`timescale 1ns/1ps
module pbm_mac_model
	import pbm_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rst_b,
	output pbm_mii_tx_s macTx
);
	logic [3:0] beat_r;
	// ==========================================================
	// Frame generator, one error beat per frame
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			beat_r <= 4'h0;
			macTx  <= '0;
		end else begin
			beat_r   <= beat_r + 4'h1;
			macTx.en <= ~beat_r[3];
			macTx.d  <= beat_r[3] ? ~macTx.d : beat_r;
			macTx.er <= (beat_r == 4'h5);
		end
	end
endmodule : pbm_mac_model

// ==== tb/pbm_basic_mode_control_tb.sv ====
// Purpose: Self-checking bench for the basic mode control block
// Assumes: 50 MHz clock, short reset sequence parameter
// Notes:   Bus tasks keep bready and rready high throughout
`timescale 1ns/1ps
module pbm_basic_mode_control_tb;
	import pbm_pkg::*;
	localparam int SWC = 12;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [AXI_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
	logic [AXI_STRB_W-1:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic irqOrPowerdownPin_b = 1, strapDuplexPin = 1, anStarted = 0;
	logic anSpeed100 = 1, anFullDuplex = 1;
	pbm_mii_tx_s miiTxIn, coreTxOut;
	pbm_mii_rx_s coreRxIn = '0, miiRxOut;
	logic miiRxOe, phyCoreReset, pwrDown, linkSpeed100, linkFullDuplex, anEnable, anRestart;
	logic [31:0] rd;
	int error_cnt = 0;
	int samples_checked = 0;
	// ==========================================================
	// Clock, receive pattern from the core side, instances
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) coreRxIn <= '{dv: 1'b1, d: coreRxIn.d + 4'h3, er: 1'b0};
	pbm_basic_mode_control #(.SW_RESET_CYCLES(SWC)) i_pbm_basic_mode_control (.*);
	pbm_mac_model i_pbm_mac_model (.core_clk, .rst_b, .macTx(miiTxIn));
	task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// ==========================================================
	// Bus cycles; a wait only ends on the answer or the watchdog
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1;
		w = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge core_clk);
			if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
			if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
		end while (!s_axi_bvalid);
		cmp_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rdr
	task automatic wait_idle;
		do rdr(OFS_STATUS); while (rd[STS_BUSY] !== 1'b0);
	endtask : wait_idle
	// MII paths against the mode: loopback, isolate, quiet
	task automatic path_chk(input logic lb, input logic iso, input logic q);
		pbm_mii_tx_s tx;
		pbm_mii_rx_s rx;
		repeat (4) begin
			@(posedge core_clk);
			tx = miiTxIn;
			rx = coreRxIn;
			@(posedge core_clk);
			if (iso || q) rx = '0;
			else if (lb) rx = pbm_mii_rx_s'(tx);
			if (iso || q || lb) tx = '0;
			cmp_word("miiRxOut", {26'h0, rx}, {26'h0, miiRxOut});
			cmp_word("coreTxOut", {26'h0, tx}, {26'h0, coreTxOut});
			cmp_bit("miiRxOe", !iso, miiRxOe);
		end
	endtask : path_chk
	task automatic mode(input logic [31:0] c, input logic lb, input logic iso, input logic q);
		wr(OFS_BASIC_CTRL, c, 4'h2, RESP_OKAY);
		tick(3);
		path_chk(lb, iso, q);
	endtask : mode
	// ==========================================================
	// Scenarios
	task automatic t_defaults;
		wait_idle();
		rdr(OFS_BASIC_CTRL);
		cmp_word("ctrl reset", 32'h0000_3100, rd);
		rdr(8'h10);
		cmp_word("unmapped rdata", 32'h0, rd);
		cmp_word("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		wr(8'h10, 32'h0000_FF00, 4'hF, RESP_SLVERR);
		$display("test defaults done");
	endtask : t_defaults
	task automatic t_swreset;
		strapDuplexPin <= 0;
		wr(OFS_BASIC_CTRL, 32'h0000_B000, 4'h2, RESP_OKAY);
		wr(OFS_BASIC_CTRL, 32'h0000_4000, 4'h2, RESP_OKAY);
		cmp_bit("phyCoreReset", 1'b1, phyCoreReset);
		rdr(OFS_BASIC_CTRL);
		cmp_bit("reset bit busy", 1'b1, rd[BIT_SWRESET]);
		wait_idle();
		rdr(OFS_BASIC_CTRL);
		cmp_word("ctrl after reset", 32'h0000_3000, rd);
		cmp_bit("phyCoreReset", 1'b0, phyCoreReset);
		strapDuplexPin <= 1;
		$display("test software reset done");
	endtask : t_swreset
	task automatic t_forced;
		for (int i = 0; i < 4; i++) begin
			wr(OFS_BASIC_CTRL, {18'h0, i[1], 4'h0, i[0], 8'h00}, 4'h2, RESP_OKAY);
			tick(3);
			cmp_bit("linkSpeed100", i[1], linkSpeed100);
			cmp_bit("linkFullDuplex", i[0], linkFullDuplex);
		end
		wr(OFS_BASIC_CTRL, 32'h0000_1000, 4'hD, RESP_OKAY);
		tick(3);
		cmp_bit("anEnable strobe off", 1'b0, anEnable);
		anSpeed100 <= 0;
		anFullDuplex <= 0;
		wr(OFS_BASIC_CTRL, 32'h0000_3100, 4'h2, RESP_OKAY);
		tick(4);
		cmp_bit("an speed", 1'b0, linkSpeed100);
		cmp_bit("an duplex", 1'b0, linkFullDuplex);
		anSpeed100 <= 1;
		anFullDuplex <= 1;
		$display("test speed and duplex done");
	endtask : t_forced
	task automatic t_restart;
		wr(OFS_BASIC_CTRL, 32'h0000_1200, 4'h2, RESP_OKAY);
		rdr(OFS_BASIC_CTRL);
		cmp_bit("restart pending", 1'b1, rd[BIT_ANRESTART]);
		cmp_bit("anRestart", 1'b1, anRestart);
		anStarted <= 1;
		tick(1);
		anStarted <= 0;
		tick(2);
		cmp_bit("anRestart cleared", 1'b0, anRestart);
		wr(OFS_BASIC_CTRL, 32'h0000_0200, 4'h2, RESP_OKAY);
		tick(2);
		cmp_bit("restart ignored", 1'b0, anRestart);
		$display("test restart done");
	endtask : t_restart
	task automatic t_mii;
		mode(32'h0000_1000, 0, 0, 0);
		mode(32'h0000_5000, 1, 0, 0);
		mode(32'h0000_1400, 0, 1, 0);
		rdr(OFS_BASIC_CTRL);
		cmp_word("ctrl isolated", 32'h0000_1400, rd);
		mode(32'h0000_1800, 0, 0, 1);
		cmp_bit("pwrDown", 1'b1, pwrDown);
		mode(32'h0000_1000, 0, 0, 0);
		cmp_bit("pwrDown", 1'b0, pwrDown);
		$display("test MII paths done");
	endtask : t_mii
	task automatic t_pin;
		irqOrPowerdownPin_b <= 0;
		tick(10);
		cmp_bit("pin pwrDown", 1'b1, pwrDown);
		rdr(OFS_STATUS);
		cmp_bit("pin request", 1'b1, rd[STS_PINPD]);
		rdr(OFS_BASIC_CTRL);
		cmp_bit("bit 11 set", 1'b1, rd[BIT_PWRDN]);
		irqOrPowerdownPin_b <= 1;
		tick(8);
		wr(OFS_BASIC_CTRL, 32'h0000_1000, 4'h2, RESP_OKAY);
		tick(3);
		cmp_bit("pwrDown released", 1'b0, pwrDown);
		$display("test power down pin done");
	endtask : t_pin
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1;
		@(posedge core_clk);
		t_defaults();
		t_swreset();
		t_forced();
		t_restart();
		t_mii();
		t_pin();
		results();
	end
	initial begin
		#400000;
		error_cnt++;
		$display("watchdog expired");
		results();
	end
endmodule : pbm_basic_mode_control_tb
bind pbm_basic_mode_control pbm_bmc_assertions #(.SW_RESET_CYCLES(SW_RESET_CYCLES))
	i_pbm_bmc_assertions (.*);
